/* flash_pw_pkg.sv */
// constants and types for the flash program and erase sequencer
package flash_pw_pkg;
    // ========================================
    // register map, word index on the port
    localparam logic [2:0] A_ADDR_LO = 3'h0; // flash_address_low
    localparam logic [2:0] A_ADDR_HI = 3'h1; // flash_address_high
    localparam logic [2:0] A_DAT_LO = 3'h2; // program_word_low_data
    localparam logic [2:0] A_DAT_HI = 3'h3; // program_word_high_data
    localparam logic [2:0] A_CTRL = 3'h4; // control and flags
    localparam logic [2:0] A_KEY = 3'h5; // unlock_key_register
    localparam logic [2:0] A_STAT = 3'h6; // interrupt status
    localparam logic [2:0] A_MASK = 3'h7; // interrupt mask
    // ========================================
    // control register bit positions
    localparam int C_START = 0;
    localparam int C_EN = 2;
    localparam int C_ERR = 3;
    localparam int C_ERASE = 4;
    localparam int C_LATCH = 5;
    // interrupt status bit positions
    localparam int S_DONE = 0;
    localparam int S_ERR = 1;
    // ========================================
    // values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] BLANK_WORD = 14'h3FFF;
    localparam logic [7:0] HI_ADDR_PAD = 8'h80; // top bit reads one
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam int ROW_WORDS = 32;
    localparam int IDX_W = 5; // word index inside a row
    localparam int ADDR_W = 15;
    localparam int ROW_W = ADDR_W - IDX_W;
    localparam int CNT_W = 16;
    // ========================================
    // types
    typedef enum logic [1:0] {UK_IDLE, UK_HALF, UK_OPEN} key_e;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} op_e;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic erase; // row erase running
        logic prog; // row program running
        logic [ROW_W-1:0] row; // target row
    } flash_cmd_s;
endpackage

/* flash_program_write_control.sv */
// flash program and erase sequencer with unlock and error logic
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_program_write_control
    import flash_pw_pkg::*;
#(
    parameter int ERASE_CYCLES = 1000, // erase time in clk cycles
    parameter int PROG_CYCLES = 500 // row program time in clk cycles
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire bus_req_s bus,
    output logic [7:0] rdata,
    input wire logic core_rst_req,
    input wire logic [ADDR_W-1:0] wp_base,
    input wire logic [IDX_W-1:0] latch_idx,
    output logic [13:0] latch_data,
    output flash_cmd_s flash_cmd,
    output logic irq
);
    // ========================================
    // state
    logic [7:0] adr_lo, next_adr_lo; // flash_address_low
    logic [6:0] adr_hi, next_adr_hi; // flash_address_high
    logic [7:0] dat_lo, next_dat_lo; // program_word_low_data
    logic [5:0] dat_hi, next_dat_hi; // program_word_high_data
    logic latch_only_select, next_latch_only_select;
    logic erase_sel, next_erase_sel;
    logic program_erase_enable, next_program_erase_enable;
    logic program_error_flag, next_program_error_flag;
    logic start, next_start;
    key_e key, next_key; // unlock progress
    op_e op, next_op; // running operation
    logic [CNT_W-1:0] cnt, next_cnt; // cycles left
    logic [1:0] stat, next_stat; // sticky events
    logic [1:0] mask, next_mask;
    logic [7:0] next_rdata;
    logic next_irq;
    flash_cmd_s next_cmd;
    logic lat_wr, lat_clr; // latch array strobes
    logic [13:0] latch [ROW_WORDS]; // row write latches
    logic [ADDR_W-1:0] addr; // full flash address
    // every check samples on clk and rests during reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // address at or above the base is write-protected
    function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
        return a >= b;
    endfunction
    // one-cycle write to a given register
    function automatic logic wr_hit(input bus_req_s q,
                                    input logic [2:0] a);
        return q.wr && (q.addr == a);
    endfunction
    assign addr = {adr_hi, adr_lo};
    // ========================================
    // next-state logic for registers and sequencer
    always_comb begin
        logic err_set, done_ev, start_wr; // per-cycle events
        err_set = 1'b0;
        done_ev = 1'b0;
        start_wr = 1'b0;
        next_adr_lo = adr_lo;
        next_adr_hi = adr_hi;
        next_dat_lo = dat_lo;
        next_dat_hi = dat_hi;
        next_latch_only_select = latch_only_select;
        next_erase_sel = erase_sel;
        next_program_erase_enable = program_erase_enable;
        next_program_error_flag = program_error_flag;
        next_start = start;
        next_key = key;
        next_op = op;
        next_cnt = cnt;
        next_mask = mask;
        next_cmd = flash_cmd;
        lat_wr = 1'b0;
        lat_clr = 1'b0;
        // plain register writes
        if (wr_hit(bus, A_ADDR_LO)) begin
            next_adr_lo = bus.wdata;
        end
        if (wr_hit(bus, A_ADDR_HI)) begin
            next_adr_hi = bus.wdata[6:0];
        end
        if (wr_hit(bus, A_DAT_LO)) begin
            next_dat_lo = bus.wdata;
        end
        if (wr_hit(bus, A_DAT_HI)) begin
            next_dat_hi = bus.wdata[5:0];
        end
        if (wr_hit(bus, A_MASK)) begin
            next_mask = bus.wdata[1:0];
        end
        if (wr_hit(bus, A_CTRL)) begin
            next_latch_only_select = bus.wdata[C_LATCH];
            next_erase_sel = bus.wdata[C_ERASE];
            next_program_erase_enable = bus.wdata[C_EN];
            // software may write the flag either way
            next_program_error_flag = bus.wdata[C_ERR];
            start_wr = bus.wdata[C_START] && !start;
        end
        // unlock key tracking: any other write breaks it
        if (wr_hit(bus, A_KEY)) begin
            if (key == UK_IDLE && bus.wdata == KEY_FIRST) begin
                next_key = UK_HALF;
            end else if (key == UK_HALF && bus.wdata == KEY_SECOND) begin
                next_key = UK_OPEN;
            end else begin
                next_key = UK_IDLE;
                err_set = (key != UK_IDLE);
            end
        end else if (bus.wr) begin
            next_key = UK_IDLE;
            // a write other than one to the control register interrupts
            err_set = !wr_hit(bus, A_CTRL) && (key != UK_IDLE);
        end
        // start dispatch; writing zero while busy is ignored
        if (start_wr && op == ST_IDLE) begin
            if (key != UK_OPEN) begin
                err_set = 1'b1;
            end else if (!bus.wdata[C_EN]) begin
                next_start = 1'b0; // inhibited
            end else if (bus.wdata[C_ERASE]) begin
                if (is_prot(addr, wp_base)) begin
                    err_set = 1'b1;
                end else begin
                    next_op = ST_ERASE; // whole row
                    next_cnt = CNT_W'(ERASE_CYCLES - 1);
                    next_start = 1'b1;
                    next_cmd.row = addr[ADDR_W-1:IDX_W];
                end
            end else if (bus.wdata[C_LATCH]) begin
                lat_wr = 1'b1; // no protect check, no flash
                done_ev = 1'b1;
            end else if (is_prot(addr, wp_base)) begin
                err_set = 1'b1;
            end else begin
                next_op = ST_PROG;
                next_cnt = CNT_W'(PROG_CYCLES - 1);
                next_start = 1'b1;
                next_cmd.row = addr[ADDR_W-1:IDX_W];
            end
        end
        // self-timed countdown, start shows busy meanwhile
        if (op != ST_IDLE) begin
            if (cnt == '0) begin
                next_op = ST_IDLE;
                next_start = 1'b0;
                lat_clr = 1'b1; // latches go blank
                done_ev = 1'b1;
            end else begin
                next_cnt = cnt - CNT_W'(1);
            end
        end
        // core reset aborts; flag survives to report it
        if (core_rst_req) begin
            err_set = err_set || (op != ST_IDLE);
            next_op = ST_IDLE;
            next_start = 1'b0;
            next_key = UK_IDLE;
            next_cnt = '0;
            next_latch_only_select = 1'b0;
            next_erase_sel = 1'b0;
            next_program_erase_enable = 1'b0;
            done_ev = 1'b0;
            lat_wr = 1'b0;
            lat_clr = 1'b0;
        end
        // hardware set beats any software clear
        if (err_set) begin
            next_program_error_flag = 1'b1;
        end
        next_cmd.erase = (next_op == ST_ERASE);
        next_cmd.prog = (next_op == ST_PROG);
        // interrupt status: read clears, set wins
        next_stat = stat;
        if (bus.rd && bus.addr == A_STAT) begin
            next_stat = 2'h0;
        end
        next_stat[S_DONE] = next_stat[S_DONE] | done_ev;
        next_stat[S_ERR] = next_stat[S_ERR] | err_set;
        next_irq = |(next_stat & next_mask);
        // read data, valid the cycle after the strobe
        next_rdata = ZERO8;
        if (bus.rd) begin
            case (bus.addr)
                A_ADDR_LO: next_rdata = adr_lo;
                A_ADDR_HI: next_rdata = HI_ADDR_PAD | {1'b0, adr_hi};
                A_DAT_LO: next_rdata = dat_lo;
                A_DAT_HI: next_rdata = {2'b00, dat_hi};
                A_CTRL: next_rdata = {2'b00, latch_only_select,
                    erase_sel, program_error_flag,
                    program_erase_enable, 1'b0, start};
                A_STAT: next_rdata = {6'h00, stat};
                A_MASK: next_rdata = {6'h00, mask};
                default: next_rdata = ZERO8; // key reads zero
            endcase
        end
    end
    // ========================================
    // register stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            adr_lo <= '0;
            adr_hi <= '0;
            dat_lo <= '0;
            dat_hi <= '0;
            latch_only_select <= 1'b0;
            erase_sel <= 1'b0;
            program_erase_enable <= 1'b0;
            program_error_flag <= 1'b0;
            start <= 1'b0;
            key <= UK_IDLE;
            op <= ST_IDLE;
            cnt <= '0;
            stat <= '0;
            mask <= '0;
            rdata <= '0;
            irq <= 1'b0;
            flash_cmd <= '0;
        end else begin
            adr_lo <= next_adr_lo;
            adr_hi <= next_adr_hi;
            dat_lo <= next_dat_lo;
            dat_hi <= next_dat_hi;
            latch_only_select <= next_latch_only_select;
            erase_sel <= next_erase_sel;
            program_erase_enable <= next_program_erase_enable;
            program_error_flag <= next_program_error_flag;
            start <= next_start;
            key <= next_key;
            op <= next_op;
            cnt <= next_cnt;
            stat <= next_stat;
            mask <= next_mask;
            rdata <= next_rdata;
            irq <= next_irq;
            flash_cmd <= next_cmd;
        end
    end
    // ========================================
    // write latches; the array streams out through latch_idx
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                latch[i] <= BLANK_WORD;
            end
            latch_data <= BLANK_WORD;
        end else begin
            if (lat_clr) begin
                for (int i = 0; i < ROW_WORDS; i++) begin
                    latch[i] <= BLANK_WORD;
                end
            end else if (lat_wr) begin
                latch[adr_lo[IDX_W-1:0]] <= {dat_hi, dat_lo};
            end
            latch_data <= latch[latch_idx];
        end
    end
    // ========================================
    // checks
    property p_key_start;
        $rose(start) |-> $past(key) == UK_OPEN;
    endproperty
    a_key_start: assert property (p_key_start)
        else $error("start set without unlock");
    property p_broken_key;
        (wr_hit(bus, A_CTRL) && bus.wdata[C_START] && key != UK_OPEN
         && op == ST_IDLE && !start)
        |=> program_error_flag && op == ST_IDLE;
    endproperty
    a_broken_key: assert property (p_broken_key)
        else $error("locked start not flagged");
    property p_prot;
        (wr_hit(bus, A_CTRL) && bus.wdata[C_START] && !start
         && bus.wdata[C_EN] && !(bus.wdata[C_LATCH] && !bus.wdata[C_ERASE])
         && key == UK_OPEN && op == ST_IDLE && !core_rst_req
         && is_prot(addr, wp_base))
        |=> program_error_flag && !start && op == ST_IDLE;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected target not refused");
    property p_core_rst;
        core_rst_req && op != ST_IDLE |=> program_error_flag && !start;
    endproperty
    a_core_rst: assert property (p_core_rst)
        else $error("aborted operation not flagged");
    property p_sticky;
        program_error_flag && !wr_hit(bus, A_CTRL) |=> program_error_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("error flag cleared by hardware");
    property p_enable;
        op != ST_IDLE && $past(op) == ST_IDLE |-> $past(bus.wdata[C_EN]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("operation ran while disabled");
    property p_busy;
        op != ST_IDLE |-> start && (flash_cmd.erase || flash_cmd.prog);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy without start");
    property p_finish;
        op == ST_PROG && cnt == '0 && !core_rst_req
        |=> !start && op == ST_IDLE ##1 latch_data == BLANK_WORD;
    endproperty
    a_finish: assert property (p_finish)
        else $error("program end not handled");
    property p_hi_read;
        bus.rd && bus.addr == A_DAT_HI |=> rdata[7:6] == 2'b00;
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("high data top bits not zero");
endmodule
`default_nettype wire

/* flash_array_model.sv */
// behavioural program flash array that times and logs row operations
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_pw_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire flash_cmd_s flash_cmd,
    input wire logic [13:0] latch_data,
    output int n_erase,
    output int n_prog,
    output int last_len,
    output logic [ROW_W-1:0] last_row,
    output logic [13:0] last_word // one stored word, for read-back
);
    int run; // cycles the running operation has been held so far
    // ========================================
    // log each operation; it ends when its level drops
    // the array has no opinion on timing, so the bench judges length
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run <= 0;
            n_erase <= 0;
            n_prog <= 0;
            last_len <= 0;
            last_row <= '0;
            last_word <= BLANK_WORD;
        end else if (flash_cmd.erase || flash_cmd.prog) begin
            run <= run + 1; // hold time in clk cycles
            last_row <= flash_cmd.row; // row under work
            if (run == 0 && flash_cmd.erase) begin
                n_erase <= n_erase + 1; // whole row erase
                last_word <= BLANK_WORD; // row reads blank now
            end else if (run == 0) begin
                n_prog <= n_prog + 1; // whole row program
                // word on show is what the row now holds
                last_word <= latch_data;
            end
        end else if (run != 0) begin
            last_len <= run; // operation finished or aborted
            run <= 0;
        end
    end
endmodule
`default_nettype wire

/* flash_program_write_control_bench.sv */
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_write_control_bench
    import flash_pw_pkg::*;
;
    localparam int ERASE_N = 30; // shortened erase time
    localparam int PROG_N = 20; // shortened program time
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    bus_req_s bus = '0;
    logic [7:0] rdata;
    logic core_rst_req = 1'b0;
    logic [ADDR_W-1:0] wp_base = '0; // everything protected at first
    logic [IDX_W-1:0] latch_idx = 5'h03;
    logic [13:0] latch_data;
    flash_cmd_s fcmd;
    logic irq;
    int n_erase, n_prog, last_len;
    logic [ROW_W-1:0] last_row;
    logic [13:0] stored; // word the array holds after an operation
    int n_fail = 0;
    int comparisons = 0;
    // ========================================
    // clock, design and far side
    always #2 clk = ~clk;
    flash_program_write_control #(.ERASE_CYCLES(ERASE_N),
        .PROG_CYCLES(PROG_N)) DUT (.clk(clk), .sys_rst(sys_rst),
        .bus(bus), .rdata(rdata), .core_rst_req(core_rst_req),
        .wp_base(wp_base), .latch_idx(latch_idx),
        .latch_data(latch_data), .flash_cmd(fcmd), .irq(irq));
    flash_array_model flash (.clk(clk), .sys_rst(sys_rst),
        .flash_cmd(fcmd), .latch_data(latch_data), .n_erase(n_erase),
        .n_prog(n_prog), .last_len(last_len), .last_row(last_row),
        .last_word(stored));
    // ========================================
    // comparison and verdict
    task automatic check(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ========================================
    // register port: one-cycle strobes, read data one cycle later
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1 d = rdata; // settled after the answering edge
    endtask
    // masked read compare; mask hides bits the rules leave open
    task automatic rcm(input logic [2:0] a, input logic [7:0] m, exp);
        logic [7:0] d;
        rd(a, d);
        check($sformatf("reg %0d", a), {8'h00, d & m}, {8'h00, exp});
    endtask
    task automatic unlock();
        wr(A_KEY, KEY_FIRST);
        wr(A_KEY, KEY_SECOND);
    endtask
    // bounded wait for the flash operation to finish
    task automatic wait_idle();
        int k;
        // look after the launching edge has settled
        #1;
        for (k = 0; k < 200 && (fcmd.erase || fcmd.prog); k++) begin
            @(posedge clk);
            #1;
        end
        check("operation ends", {15'h0, fcmd.erase | fcmd.prog}, 16'h0000);
        // one more edge so the array log and latch view catch up
        @(posedge clk);
        #1;
    endtask
    // ========================================
    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #(4 * 5000);
        n_fail++;
        tally_and_finish();
    end
    // ========================================
    // main sequence
    initial begin
        logic [7:0] d;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rcm(A_CTRL, 8'hFF, 8'h00);
        wr(A_DAT_HI, 8'hFF);
        rcm(A_DAT_HI, 8'hFF, 8'h3F);
        wr(A_DAT_LO, 8'hA5);
        rcm(A_DAT_LO, 8'hFF, 8'hA5);
        wr(A_ADDR_HI, 8'h01);
        rcm(A_ADDR_HI, 8'hFF, 8'h81);
        wr(A_ADDR_LO, 8'h23);
        wr(A_DAT_LO, 8'h34);
        wr(A_DAT_HI, 8'h12);
        wr(A_CTRL, 8'h08);
        rcm(A_CTRL, 8'hFF, 8'h08);
        wr(A_CTRL, 8'h00);
        rcm(A_CTRL, 8'hFF, 8'h00);
        // key broken by another write
        wr(A_KEY, KEY_FIRST);
        wr(A_DAT_LO, 8'h34);
        rcm(A_CTRL, 8'h08, 8'h08);
        wr(A_CTRL, 8'h00);
        // a write between key and start closes the lock
        unlock();
        wr(A_DAT_LO, 8'h34);
        wr(A_CTRL, 8'h05);
        rcm(A_CTRL, 8'h09, 8'h08);
        check("programs", 16'(n_prog), 16'h0000);
        check("irq masked", {15'h0, irq}, 16'h0000);
        rcm(A_STAT, 8'h02, 8'h02);
        wr(A_CTRL, 8'h00);
        // enable low: nothing at all
        unlock();
        wr(A_CTRL, 8'h01);
        rcm(A_CTRL, 8'hFF, 8'h00);
        // latch load ignores protection
        unlock();
        wr(A_CTRL, 8'h25);
        rcm(A_CTRL, 8'h09, 8'h00);
        check("latch", {2'b00, latch_data}, 16'h1234);
        // protected program and erase
        unlock();
        wr(A_CTRL, 8'h05);
        rcm(A_CTRL, 8'h09, 8'h08);
        check("latch kept", {2'b00, latch_data}, 16'h1234);
        wr(A_CTRL, 8'h00);
        unlock();
        wr(A_CTRL, 8'h15);
        rcm(A_CTRL, 8'h09, 8'h08);
        check("ops", 16'(n_prog + n_erase), 16'h0000);
        wr(A_CTRL, 8'h00);
        rd(A_STAT, d);
        // program an open row with done interrupt unmasked
        @(posedge clk);
        wp_base <= 15'h4000;
        wr(A_MASK, 8'h01);
        unlock();
        wr(A_CTRL, 8'h05);
        rcm(A_CTRL, 8'h01, 8'h01);
        wr(A_CTRL, 8'h00);
        rcm(A_CTRL, 8'h01, 8'h01);
        wait_idle();
        check("programs", 16'(n_prog), 16'h0001);
        check("program time", 16'(last_len), 16'(PROG_N));
        check("row", {6'h00, last_row}, 16'h0009);
        check("row verify", {2'b00, stored}, 16'h1234);
        check("latch blank", {2'b00, latch_data}, 16'h3FFF);
        rcm(A_CTRL, 8'h09, 8'h00);
        check("irq done", {15'h0, irq}, 16'h0001);
        rcm(A_STAT, 8'hFF, 8'h01);
        @(posedge clk);
        #1 check("irq cleared", {15'h0, irq}, 16'h0000);
        // erase with latch-only also set
        unlock();
        wr(A_CTRL, 8'h35);
        wait_idle();
        check("erases", 16'(n_erase), 16'h0001);
        check("erase time", 16'(last_len), 16'(ERASE_N));
        check("row", {6'h00, last_row}, 16'h0009);
        check("row erased", {2'b00, stored}, 16'h3FFF);
        wr(A_MASK, 8'h00);
        // warm reset in mid-program
        unlock();
        wr(A_CTRL, 8'h05);
        repeat (3) @(posedge clk);
        core_rst_req <= 1'b1;
        @(posedge clk);
        core_rst_req <= 1'b0;
        rcm(A_CTRL, 8'h09, 8'h08);
        check("aborted", {15'h0, fcmd.prog}, 16'h0000);
        wr(A_CTRL, 8'h00);
        rcm(A_CTRL, 8'h08, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
